// ---- core/bopc_top.sv ----
// Purpose: Two binary outputs driven from indications or energy counters.
// Assumes: Indications, validity and energy ticks come from logic on clk_i.
// Notes:   Settings go to a shadow set and act only after an activation pulse.
// Contract
// R1: Each output uses one source kind, indication by default.
// R2: Indication selection none disables the output, held inactive.
// R3: Optional inversion of the indication before the mode; default off.
// R4: Persistent mode follows indication; invalid indication keeps present state.
// R5: Fail-safe mode: invalid forces OFF, or ON when inverted.
// R6: Pulse mode: change starts a pulse; changes during it are ignored.
// R7: Retrigger mode: change during a pulse restarts its timer.
// R8: Pulse width is x times 10 ms, range 50 ms to 3600000 ms.
// R9: Pulse width count resets to 20, that is 200 ms.
// R10: Pulse width used only in pulse modes or energy source.
// R11: Energy source pulses once per increment, 0.1 to 1000000, default 1.0.
// R12: Energy settings only act when the source kind is energy.
// R13: Both outputs are identical independently configured instances.
// R14: Written settings stay in a shadow set until activation copies them.
// R15: On activation persistent outputs take the state under the new settings.
// R16: On activation an output mid-pulse is switched OFF at once.
// R17: After reset outputs are OFF and all pulse timers cleared.
`timescale 1ns/1ps
`default_nettype none
module bopc_top #(
  parameter int TICK_CYCLES = bopc_pkg::TICK_CYC
) (
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic [bopc_pkg::IND_N-1:0]        ind_i,
  input  wire logic [bopc_pkg::IND_N-1:0]        ind_valid_i,
  input  wire logic [bopc_pkg::EN_N-1:0]         energy_tick_i,
  input  wire logic                              cfg_we_i,
  input  wire logic                              cfg_ch_i,
  input  wire bopc_pkg::bopc_src_t               cfg_src_i,
  input  wire logic [bopc_pkg::IND_W-1:0]        cfg_ind_sel_i,
  input  wire logic                              cfg_inv_i,
  input  wire bopc_pkg::bopc_mode_t              cfg_mode_i,
  input  wire logic [bopc_pkg::EN_W-1:0]         cfg_en_sel_i,
  input  wire logic [bopc_pkg::INC_W-1:0]        cfg_inc_i,
  input  wire logic [bopc_pkg::WID_W-1:0]        cfg_wid_i,
  input  wire logic                              activate_i,
  output logic [bopc_pkg::CH_N-1:0]              bo_o,
  output logic [bopc_pkg::CH_N-1:0]              pulse_busy_o
);

  localparam int PW = $clog2(TICK_CYCLES + 1);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [bopc_pkg::WID_W-1:0] clamp_wid(
    input logic [bopc_pkg::WID_W-1:0] v
  );
    logic [bopc_pkg::WID_W-1:0] r;
    r = v;
    if (v < bopc_pkg::WID_MIN)
    begin
      r = bopc_pkg::WID_MIN;
    end
    else if (v > bopc_pkg::WID_MAX)
    begin
      r = bopc_pkg::WID_MAX;
    end
    return r;
  endfunction : clamp_wid

  function automatic logic [bopc_pkg::INC_W-1:0] clamp_inc(
    input logic [bopc_pkg::INC_W-1:0] v
  );
    logic [bopc_pkg::INC_W-1:0] r;
    r = v;
    if (v < bopc_pkg::INC_MIN)
    begin
      r = bopc_pkg::INC_MIN;
    end
    else if (v > bopc_pkg::INC_MAX)
    begin
      r = bopc_pkg::INC_MAX;
    end
    return r;
  endfunction : clamp_inc

  // Level state implied by a persistent mode, given the present output.
  function automatic logic persist_level(
    input bopc_pkg::bopc_cfg_t c,
    input logic                lvl,
    input logic                vld,
    input logic                cur
  );
    logic r;
    r = cur;
    if (c.ind_sel == bopc_pkg::IND_NONE)
    begin
      r = 1'b0;
    end
    else if (vld)
    begin
      r = lvl;
    end
    else if (c.mode == bopc_pkg::BOPC_FAILSAFE)
    begin
      r = c.inv;
    end
    return r;
  endfunction : persist_level

  // ************************************************************
  // Shadow and active parameter sets
  // ************************************************************
  bopc_pkg::bopc_cfg_t shd_q [bopc_pkg::CH_N];
  bopc_pkg::bopc_cfg_t shd_d [bopc_pkg::CH_N];
  bopc_pkg::bopc_cfg_t act_q [bopc_pkg::CH_N];
  bopc_pkg::bopc_cfg_t act_d [bopc_pkg::CH_N];

  always_comb
  begin
    for (int c = 0; c < bopc_pkg::CH_N; c++)
    begin
      shd_d[c] = shd_q[c];
      act_d[c] = act_q[c];
      // R14: write lands in shadow
      if (cfg_we_i && (cfg_ch_i == c[0]))
      begin
        shd_d[c].src     = cfg_src_i;
        shd_d[c].ind_sel = cfg_ind_sel_i;
        shd_d[c].inv     = cfg_inv_i;
        shd_d[c].mode    = cfg_mode_i;
        shd_d[c].en_sel  = cfg_en_sel_i;
        // R11: clamp increment range
        shd_d[c].inc     = clamp_inc(cfg_inc_i);
        // R8: clamp width range
        shd_d[c].wid     = clamp_wid(cfg_wid_i);
      end
      // R14: activation copies shadow
      if (activate_i)
      begin
        act_d[c] = shd_q[c];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < bopc_pkg::CH_N; c++)
      begin
        // R1: indication default source
        // R9: width resets to 20
        shd_q[c] <= bopc_pkg::CFG_RST;
        act_q[c] <= bopc_pkg::CFG_RST;
      end
    end
    else
    begin
      for (int c = 0; c < bopc_pkg::CH_N; c++)
      begin
        shd_q[c] <= shd_d[c];
        act_q[c] <= act_d[c];
      end
    end
  end

  // ************************************************************
  // Shared 10 ms tick prescaler
  // ************************************************************
  logic [PW-1:0] pre_q;
  logic [PW-1:0] pre_d;
  logic          tick_q;
  logic          tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    pre_d  = pre_q + 1'b1;
    // R8: one tick per 10 ms
    if (pre_q == PW'(TICK_CYCLES - 1))
    begin
      pre_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // ************************************************************
  // Output channels
  // ************************************************************
  // R13: identical channel instances
  for (genvar g = 0; g < bopc_pkg::CH_N; g++)
  begin : g_ch
    bopc_pulse_if pif ();

    logic                       out_q;
    logic                       out_d;
    logic                       prev_q;
    logic                       prev_d;
    logic [bopc_pkg::INC_W-1:0] acc_q;
    logic [bopc_pkg::INC_W-1:0] acc_d;
    logic                       lvl;
    logic                       vld;
    logic                       new_lvl;
    logic                       new_vld;
    logic                       en_tick;

    bopc_pulse_timer u_timer (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pif   (pif.timer)
    );

    always_comb
    begin
      // R3: invert before mode
      lvl     = ind_i[act_q[g].ind_sel] ^ act_q[g].inv;
      vld     = ind_valid_i[act_q[g].ind_sel];
      new_lvl = ind_i[shd_q[g].ind_sel] ^ shd_q[g].inv;
      new_vld = ind_valid_i[shd_q[g].ind_sel];
      en_tick = 1'b0;
      if (act_q[g].en_sel != bopc_pkg::EN_NONE)
      begin
        en_tick = energy_tick_i[act_q[g].en_sel - 1'b1];
      end

      out_d      = out_q;
      prev_d     = vld ? lvl : prev_q;
      acc_d      = acc_q;
      pif.start  = 1'b0;
      pif.retrig = 1'b0;
      pif.clear  = 1'b0;
      pif.tick   = tick_q;
      // R10: width only for pulses
      pif.width  = act_q[g].wid;

      if (activate_i)
      begin
        // R16: cut running pulse
        pif.clear = 1'b1;
        acc_d     = '0;
        prev_d    = new_vld ? new_lvl : prev_q;
        out_d     = 1'b0;
        // R15: persistent takes new state
        if ((shd_q[g].src == bopc_pkg::BOPC_SRC_IND) &&
            ((shd_q[g].mode == bopc_pkg::BOPC_PERSIST) ||
             (shd_q[g].mode == bopc_pkg::BOPC_FAILSAFE)))
        begin
          out_d = persist_level(shd_q[g], new_lvl, new_vld, out_q);
        end
      end
      // R1: energy source kind
      else if (act_q[g].src == bopc_pkg::BOPC_SRC_EN)
      begin
        // R12: energy settings act here
        // R11: one pulse per increment
        if (en_tick)
        begin
          if (acc_q + 1'b1 >= act_q[g].inc)
          begin
            acc_d     = '0;
            pif.start = 1'b1;
          end
          else
          begin
            acc_d = acc_q + 1'b1;
          end
        end
        out_d = pif.busy;
      end
      // R2: none disables output
      else if (act_q[g].ind_sel == bopc_pkg::IND_NONE)
      begin
        pif.clear = 1'b1;
        out_d     = 1'b0;
      end
      else
      begin
        unique case (act_q[g].mode)
          // R4: follow, hold on invalid
          // R5: fail-safe on invalid
          bopc_pkg::BOPC_PERSIST,
          bopc_pkg::BOPC_FAILSAFE:
          begin
            pif.clear = 1'b1;
            out_d     = persist_level(act_q[g], lvl, vld, out_q);
          end
          // R6: change starts pulse
          bopc_pkg::BOPC_PULSE:
          begin
            pif.start = vld && (lvl != prev_q);
            out_d     = pif.busy;
          end
          // R7: change retriggers pulse
          bopc_pkg::BOPC_PULSE_RT:
          begin
            pif.start  = vld && (lvl != prev_q);
            pif.retrig = 1'b1;
            out_d      = pif.busy;
          end
        endcase
      end
    end

    always_ff @(posedge clk_i)
    begin
      // R17: outputs OFF after reset
      if (rst_i)
      begin
        out_q  <= 1'b0;
        prev_q <= 1'b0;
        acc_q  <= '0;
      end
      else
      begin
        out_q  <= out_d;
        prev_q <= prev_d;
        acc_q  <= acc_d;
      end
    end

    assign bo_o[g]         = out_q;
    assign pulse_busy_o[g] = pif.busy;
  end

endmodule : bopc_top
`default_nettype wire

// ---- core/bopc_pkg.sv ----
// Purpose: Shared constants and types for the binary output pulse control block.
// Assumes: 200 MHz system clock, one synchronous active-high reset.
// Notes:   Pulse widths are counted in 10 ms steps; energy increments in tenths of a unit.
package bopc_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int CH_N  = 2;
  localparam int IND_N = 16;
  localparam int IND_W = 4;
  localparam int EN_N  = 3;
  localparam int EN_W  = 2;
  localparam int WID_W = 19;
  localparam int INC_W = 24;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_KHZ      = 200000;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYC     = TICK_MS * CLK_KHZ;
  localparam int PULSE_MIN_MS = 50;
  localparam int PULSE_MAX_MS = 3600000;

  // ************************************************************
  // Setting limits and reset values
  // ************************************************************
  localparam logic [WID_W-1:0] WID_MIN = WID_W'(PULSE_MIN_MS / TICK_MS);
  localparam logic [WID_W-1:0] WID_MAX = WID_W'(PULSE_MAX_MS / TICK_MS);
  localparam logic [WID_W-1:0] WID_RST = 19'h00014;
  localparam logic [INC_W-1:0] INC_MIN = 24'h000001;
  localparam logic [INC_W-1:0] INC_MAX = 24'h989680;
  localparam logic [INC_W-1:0] INC_RST = 24'h00000A;
  localparam logic [IND_W-1:0] IND_NONE = 4'h0;
  localparam logic [EN_W-1:0]  EN_NONE  = 2'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    BOPC_PERSIST   = 2'b00,
    BOPC_FAILSAFE  = 2'b01,
    BOPC_PULSE     = 2'b10,
    BOPC_PULSE_RT  = 2'b11
  } bopc_mode_t;

  typedef enum logic {
    BOPC_SRC_IND = 1'b0,
    BOPC_SRC_EN  = 1'b1
  } bopc_src_t;

  typedef struct packed {
    bopc_src_t        src;
    logic [IND_W-1:0] ind_sel;
    logic             inv;
    bopc_mode_t       mode;
    logic [EN_W-1:0]  en_sel;
    logic [INC_W-1:0] inc;
    logic [WID_W-1:0] wid;
  } bopc_cfg_t;

  localparam bopc_cfg_t CFG_RST = '{
    src:     BOPC_SRC_IND,
    ind_sel: IND_NONE,
    inv:     1'b0,
    mode:    BOPC_PERSIST,
    en_sel:  EN_NONE,
    inc:     INC_RST,
    wid:     WID_RST
  };

endpackage : bopc_pkg

// ---- core/bopc_pulse_if.sv ----
// Purpose: Carrier between an output channel and its pulse timer.
// Assumes: Both ends run on the system clock.
// Notes:   None.
`timescale 1ns/1ps
`default_nettype none
interface bopc_pulse_if;
  logic                       start;
  logic                       retrig;
  logic                       clear;
  logic                       tick;
  logic [bopc_pkg::WID_W-1:0] width;
  logic                       busy;

  modport ctrl  (output start, output retrig, output clear, output tick, output width,
                 input busy);
  modport timer (input start, input retrig, input clear, input tick, input width,
                 output busy);
endinterface : bopc_pulse_if
`default_nettype wire

// ---- core/bopc_pulse_timer.sv ----
// Purpose: Pulse timer counting output time in 10 ms ticks.
// Assumes: Tick is a one-cycle pulse from the shared prescaler.
// Notes:   Busy is registered and stays high while ticks remain.
`timescale 1ns/1ps
`default_nettype none
module bopc_pulse_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  bopc_pulse_if.timer      pif
);

  logic [bopc_pkg::WID_W-1:0] cnt_q;
  logic [bopc_pkg::WID_W-1:0] cnt_d;
  logic                       busy_q;
  logic                       busy_d;

  // ************************************************************
  // Next count
  // ************************************************************
  always_comb
  begin
    cnt_d = cnt_q;
    // R16: activation cuts pulse
    if (pif.clear)
    begin
      cnt_d = '0;
    end
    // R6: ignore while busy
    // R7: restart while busy
    else if (pif.start && (!busy_q || pif.retrig))
    begin
      cnt_d = pif.width;
    end
    // R8: count 10 ms steps
    else if (pif.tick && (cnt_q != '0))
    begin
      cnt_d = cnt_q - 1'b1;
    end
    busy_d = (cnt_d != '0);
  end

  always_ff @(posedge clk_i)
  begin
    // R17: timers cleared
    if (rst_i)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign pif.busy = busy_q;

endmodule : bopc_pulse_timer
`default_nettype wire

// ---- test/bopc_assertions.sv ----
// Purpose: Port-level checker for the binary output block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound into bopc_top; pulse limits follow the tick parameter.
`timescale 1ns/1ps
`default_nettype none
module bopc_assertions #(
  parameter int TICK_CYCLES = 4
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      activate_i,
  input  wire logic [bopc_pkg::CH_N-1:0] bo_o,
  input  wire logic [bopc_pkg::CH_N-1:0] pulse_busy_o
);
  localparam int MIN_RUN = (int'(bopc_pkg::WID_MIN) - 1) * TICK_CYCLES + 1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_release: assert property ($fell(rst_i) |-> bo_o == '0 && pulse_busy_o == '0)
    else $error("outputs not idle at reset release");
  a_reset_quiet: assert property ($fell(rst_i) && !activate_i |=> bo_o == '0)
    else $error("output set before any activation");
  a_act_clear: assert property (activate_i |=> pulse_busy_o == '0)
    else $error("pulse timer still running after activation");

  for (genvar k = 0; k < bopc_pkg::CH_N; k++)
  begin : g_ch
    logic [31:0] run_q;
    logic [31:0] run_d;
    always_comb run_d = pulse_busy_o[k] ? run_q + 32'h1 : 32'h0;
    always_ff @(posedge clk_i) run_q <= rst_i ? 32'h0 : run_d;

    a_busy_to_out: assert property ($rose(pulse_busy_o[k]) && !activate_i |=> bo_o[k])
      else $error("pulse start did not raise the output");
    a_busy_rise_clean: assert property ($rose(pulse_busy_o[k]) |-> !bo_o[k])
      else $error("output high before pulse start");
    a_busy_hold_out: assert property (
      pulse_busy_o[k] && $past(pulse_busy_o[k]) && !$past(activate_i) |-> bo_o[k])
      else $error("output low during running pulse");
    a_busy_end_out: assert property (
      $fell(pulse_busy_o[k]) && !$past(activate_i) && !activate_i |=> !bo_o[k])
      else $error("output high after pulse end");
    a_pulse_min_len: assert property (
      $fell(pulse_busy_o[k]) && !$past(activate_i) |-> run_q >= MIN_RUN)
      else $error("pulse shorter than the minimum width");
  end
endmodule : bopc_assertions

bind bopc_top bopc_assertions #(.TICK_CYCLES(TICK_CYCLES)) bopc_assertions_i (
  .clk_i(clk_i), .rst_i(rst_i), .activate_i(activate_i), .bo_o(bo_o),
  .pulse_busy_o(pulse_busy_o));
`default_nettype wire

// ---- test/bopc_contact_model.sv ----
// Purpose: Contact input wired to the binary outputs; counts closures.
// Assumes: Contacts are sampled on the system clock.
// Notes:   A closure is a rising edge of the output level.
`timescale 1ns/1ps
`default_nettype none
module bopc_contact_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  bo_i,
  output logic [1:0][15:0] pulses_o
);
  logic [1:0] last_q;
  always_ff @(posedge clk_i)
  begin
    last_q <= rst_i ? 2'h0 : bo_i;
    for (int i = 0; i < 2; i++)
      pulses_o[i] <= rst_i ? 16'h0000 : pulses_o[i] + 16'(bo_i[i] & ~last_q[i]);
  end
endmodule : bopc_contact_model
`default_nettype wire

// ---- test/bopc_top_tb.sv ----
// Purpose: Self-checking bench for the binary output block.
// Assumes: Tick shortened to 4 cycles; 200 MHz clock.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`default_nettype none
module bopc_top_tb;
  localparam int T = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] ind_i = 16'h0000;
  logic [15:0] ind_valid_i = 16'h0000;
  logic [2:0] energy_tick_i = 3'h0;
  logic cfg_we_i = 1'b0;
  logic cfg_ch_i = 1'b0;
  bopc_pkg::bopc_src_t cfg_src_i = bopc_pkg::BOPC_SRC_IND;
  logic [3:0] cfg_ind_sel_i = 4'h0;
  logic cfg_inv_i = 1'b0;
  bopc_pkg::bopc_mode_t cfg_mode_i = bopc_pkg::BOPC_PERSIST;
  logic [1:0] cfg_en_sel_i = 2'h0;
  logic [23:0] cfg_inc_i = 24'h00000A;
  logic [18:0] cfg_wid_i = 19'h00014;
  logic activate_i = 1'b0;
  logic [1:0] bo_o;
  logic [1:0] pulse_busy_o;
  logic [1:0][15:0] pulses;
  int fails = 0;
  int n_compared = 0;
  int len;
  logic [15:0] p0;

  always #2.5 clk_i = ~clk_i;

  bopc_top #(.TICK_CYCLES(T)) bopc_top_i (.clk_i(clk_i), .rst_i(rst_i), .ind_i(ind_i),
    .ind_valid_i(ind_valid_i), .energy_tick_i(energy_tick_i), .cfg_we_i(cfg_we_i),
    .cfg_ch_i(cfg_ch_i), .cfg_src_i(cfg_src_i), .cfg_ind_sel_i(cfg_ind_sel_i),
    .cfg_inv_i(cfg_inv_i), .cfg_mode_i(cfg_mode_i), .cfg_en_sel_i(cfg_en_sel_i),
    .cfg_inc_i(cfg_inc_i), .cfg_wid_i(cfg_wid_i), .activate_i(activate_i), .bo_o(bo_o),
    .pulse_busy_o(pulse_busy_o));
  bopc_contact_model bopc_contact_model_i (.clk_i(clk_i), .rst_i(rst_i), .bo_i(bo_o),
    .pulses_o(pulses));

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  task automatic cfg(input logic ch, input bopc_pkg::bopc_src_t src, input logic [3:0] sel,
      input logic inv, input bopc_pkg::bopc_mode_t md, input logic [1:0] en,
      input logic [23:0] inc, input logic [18:0] wid);
    @(posedge clk_i);
    cfg_we_i <= 1'b1;
    cfg_ch_i <= ch;
    cfg_src_i <= src;
    cfg_ind_sel_i <= sel;
    cfg_inv_i <= inv;
    cfg_mode_i <= md;
    cfg_en_sel_i <= en;
    cfg_inc_i <= inc;
    cfg_wid_i <= wid;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
  endtask : cfg

  task automatic act();
    @(posedge clk_i);
    activate_i <= 1'b1;
    @(posedge clk_i);
    activate_i <= 1'b0;
    #1;
  endtask : act

  task automatic ind(input int b, input logic v, input logic vld);
    @(posedge clk_i);
    ind_i[b] <= v;
    ind_valid_i[b] <= vld;
  endtask : ind

  task automatic etick(input logic [2:0] m);
    @(posedge clk_i);
    energy_tick_i <= m;
    @(posedge clk_i);
    energy_tick_i <= 3'h0;
  endtask : etick

  // Times an output pulse and flips the indication once, k cycles into it.
  task automatic plen(input int ch, input int b, input int k, output int n);
    int w;
    w = 0;
    n = 0;
    while (bo_o[ch] !== 1'b1 && w < 20)
    begin
      wt(1);
      w++;
    end
    while (bo_o[ch] === 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      if (n == k) ind_i[b] <= ~ind_i[b];
      #1;
      n++;
    end
  endtask : plen

  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({bo_o, pulse_busy_o}, 32'h0);
    $display("test reset done");
    cfg(0, bopc_pkg::BOPC_SRC_IND, 4'h1, 0, bopc_pkg::BOPC_PERSIST, 2'h1, 24'h1, 19'h5);
    ind(1, 1, 1);
    wt(3);
    chk(bo_o[0], 1'b0);
    act();
    wt(1);
    chk(bo_o[0], 1'b1);
    etick(3'h1);
    ind(1, 0, 1);
    wt(2);
    chk(bo_o[0], 1'b0);
    ind(1, 1, 0);
    wt(2);
    chk(bo_o[0], 1'b0);
    ind(1, 1, 1);
    wt(2);
    chk(bo_o[0], 1'b1);
    $display("test persistent done");
    for (int v = 0; v < 2; v++)
    begin
      cfg(1, bopc_pkg::BOPC_SRC_IND, 4'h2, v[0], bopc_pkg::BOPC_FAILSAFE, 2'h0, 24'h1, 19'h5);
      act();
      ind(2, 1, 1);
      wt(2);
      chk(bo_o[1], !v[0]);
      ind(2, 1, 0);
      wt(2);
      chk(bo_o[1], v[0]);
    end
    cfg(1, bopc_pkg::BOPC_SRC_IND, 4'h0, 1, bopc_pkg::BOPC_PERSIST, 2'h0, 24'h1, 19'h5);
    act();
    wt(2);
    chk(bo_o[1], 1'b0);
    $display("test fail-safe done");
    ind(3, 0, 1);
    for (int m = 2; m < 4; m++)
    begin
      cfg(0, bopc_pkg::BOPC_SRC_IND, 4'h3, 0, bopc_pkg::bopc_mode_t'(m), 2'h0, 24'h1,
          (m == 2) ? 19'h1 : 19'h5);
      act();
      ind(3, ~ind_i[3], 1);
      plen(0, 3, 8, len);
      if (m == 2)
        chk_rng(len, 4 * T + 1, 5 * T + 1);
      else
        chk_rng(len, 4 * T + 8, 5 * T + 13);
      wt(10);
      chk(bo_o[0], 1'b0);
    end
    $display("test pulse done");
    ind(3, ~ind_i[3], 1);
    wt(5);
    chk(pulse_busy_o[0], 1'b1);
    act();
    chk({bo_o[0], pulse_busy_o[0]}, 32'h0);
    $display("test activation done");
    cfg(1, bopc_pkg::BOPC_SRC_EN, 4'h2, 0, bopc_pkg::BOPC_PULSE, 2'h2, 24'h3, 19'h5);
    act();
    p0 = pulses[1];
    repeat (3) etick(3'h5);
    ind(2, ~ind_i[2], 1);
    repeat (2) etick(3'h2);
    wt(25);
    chk(pulses[1], p0);
    etick(3'h2);
    wt(2);
    chk(bo_o[1], 1'b1);
    wt(25);
    chk(pulses[1], p0 + 16'h1);
    $display("test energy done");
    report_and_stop();
  end
endmodule : bopc_top_tb
`default_nettype wire
